// ---- rtl/bips_params.svh ----
// Constants for the backend input stage, statistics monitor and prescaler.
// Assumes one ref_clk domain and the byte-wide host register port.
//
// What this block does
// RULE_01 - MAC result shifts right up to 8 with rounding, or left up to 8.
// RULE_02 - Adder adds shifted value and rounding to cascade input or zero.
// RULE_03 - 22-bit signed sum flags positive or negative overflow.
// RULE_04 - Two-bit field picks none, full-wave or half-wave rectification.
// RULE_05 - Overflow flags travel with each result sample.
// RULE_06 - Monitor observes the result bus and never alters it.
// RULE_07 - Two control bits choose one of four monitor functions.
// RULE_08 - Overshoot counts samples above threshold, and positive overflows.
// RULE_09 - Event counter saturates at 3fffff.
// RULE_10 - Undershoot counts samples below threshold, and negative overflows.
// RULE_11 - Capture loads each new extreme and increments the counter.
// RULE_12 - Overflowed samples never load the threshold.
// RULE_13 - Threshold bits 22 and 23 stick on positive and negative overflow.
// RULE_14 - Threshold copy write clears both sticky flags.
// RULE_15 - Copy write moves buffer into threshold register.
// RULE_16 - Copy read snapshots threshold register into buffer.
// RULE_17 - Counter uses the same two-step copy at its own location.
// RULE_18 - Copies work any cycle without stalling data.
// RULE_19 - Result bus shifts right 0 to 16; low byte is table address.
// RULE_20 - Signed address: fault if bits above byte differ from its top bit.
// RULE_21 - Unsigned address: fault if bits above byte set; negative underselects.
// RULE_22 - Address leaves with faults and overflow flags of its sample.
// RULE_23 - After reset the monitor is in minimum capture.
// RULE_24 - Encodings are named constants; rectifier code 00 means none.
// RULE_25 - Each stage registers once per clock, flags aligned with data.
`ifndef BIPS_PARAMS_SVH
`define BIPS_PARAMS_SVH

`define BIPS_ADR_IN_CTRL 9'h0a0
`define BIPS_ADR_MON_CTRL 9'h0a1
`define BIPS_ADR_PRE_CTRL 9'h0a2
`define BIPS_ADR_SYS_CTRL 9'h0a3
`define BIPS_ADR_THR_COPY 9'h0b4
`define BIPS_ADR_THR_BUF 9'h0b5
`define BIPS_ADR_CNT_COPY 9'h0bc
`define BIPS_ADR_CNT_BUF 9'h0bd
`define BIPS_CASC_ZERO_BIT 0
`define BIPS_SHIFT_MSB 5
`define BIPS_SHIFT_LSB 1
`define BIPS_RECT_MSB 7
`define BIPS_RECT_LSB 6
`define BIPS_MON_MAX_BIT 0
`define BIPS_MON_STATIC_BIT 1
`define BIPS_PRE_AMT_MSB 4
`define BIPS_UNSIGNED_ADDR_BIT 6
`define BIPS_POS_STICKY_BIT 22
`define BIPS_NEG_STICKY_BIT 23
`define BIPS_SHIFT_MAX 5'h08
`define BIPS_PRE_MAX 5'h10
`define BIPS_RECT_NONE 2'h0
`define BIPS_RECT_FULL 2'h1
`define BIPS_RECT_HALF 2'h2
`define BIPS_CNT_MAX 22'h3fffff
`define BIPS_CTRL_RESET 8'h00

`endif

// ---- rtl/bips_pkg.sv ----
// Types shared by the backend input and monitor logic.
// Assumes the constants header is compiled alongside.
package bips_pkg;

    // Monitor function, one-hot
    typedef enum logic [3:0] {
        BIPS_MON_MIN = 4'b0001,
        BIPS_MON_MAX = 4'b0010,
        BIPS_MON_UNDER = 4'b0100,
        BIPS_MON_OVER = 4'b1000
    } bips_mon_fn_t;

    typedef logic [21:0] bips_word_t;

endpackage

// ---- rtl/bips_input_stage.sv ----
// Scaling shifter, cascade adder and rectifier: two register stages.
// Assumes controls are static or change between samples.
`include "bips_params.svh"

module bips_input_stage
    import bips_pkg::*;
#(
    parameter int W = 22
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Operands
    input wire logic [W-1:0] mac_word,
    input wire logic [W-1:0] cascade_in,
    // Controls
    input wire logic [4:0] shift_code,
    input wire logic cascade_zero,
    input wire logic [1:0] rect_sel,
    // Result
    output logic [W-1:0] result_bus,
    output logic pos_ovf,
    output logic neg_ovf
);

    generate
        if (W < 9)
        begin
            $error("bips_input_stage: W too small");
        end
    endgenerate

    logic [4:0] mag;
    logic [3:0] amt;
    logic right;
    logic [W-1:0] shifted;
    logic [W-1:0] rnd_vec;
    logic rnd;
    logic [W-1:0] addend;
    logic [W:0] sum_ext;
    logic [W-1:0] sum_reg;
    logic sum_pos_reg;
    logic sum_neg_reg;
    logic sum_neg_sign;

    // Code is two's complement: positive shifts right, beyond 8 clamps
    always_comb
    begin
        right = !shift_code[4];
        mag = right ? shift_code : 5'(-shift_code);
        amt = (mag > `BIPS_SHIFT_MAX) ? 4'(`BIPS_SHIFT_MAX) : mag[3:0];
        shifted = right ? W'($signed(mac_word) >>> amt) : W'(mac_word << amt); // RULE_01
        rnd_vec = mac_word >> (amt - 4'h1);
        rnd = right && (amt != 4'h0) && rnd_vec[0]; // RULE_01
        addend = cascade_zero ? '0 : cascade_in; // RULE_02
        sum_ext = {shifted[W-1], shifted} + {addend[W-1], addend}
            + {{W{1'b0}}, rnd}; // RULE_02
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sum_reg <= '0;
            sum_pos_reg <= 1'b0;
            sum_neg_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            sum_reg <= sum_ext[W-1:0]; // RULE_25
            sum_pos_reg <= (sum_ext[W:W-1] == 2'b01); // RULE_03
            sum_neg_reg <= (sum_ext[W:W-1] == 2'b10); // RULE_03
        end
    end

    assign sum_neg_sign = sum_reg[W-1];

    // Full wave of the most negative value saturates to the largest positive
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            result_bus <= '0;
            pos_ovf <= 1'b0;
            neg_ovf <= 1'b0;
        end
        else if (clk_en)
        begin
            case (rect_sel) // RULE_04 RULE_24
                `BIPS_RECT_FULL:
                    if (sum_neg_sign)
                        result_bus <= (sum_reg == {1'b1, {(W-1){1'b0}}})
                            ? {1'b0, {(W-1){1'b1}}} : W'(-sum_reg);
                    else
                        result_bus <= sum_reg;
                `BIPS_RECT_HALF:
                    result_bus <= sum_neg_sign ? '0 : sum_reg;
                default:
                    result_bus <= sum_reg;
            endcase
            pos_ovf <= sum_pos_reg; // RULE_05
            neg_ovf <= sum_neg_reg; // RULE_05
        end
    end

endmodule

// ---- rtl/bips_backend_input.sv ----
// Backend front half: input stage, statistics monitor, prescaler and
// select detector, with the byte-wide host register port.
// Assumes host accesses and data are synchronous to ref_clk.
`include "bips_params.svh"

module bips_backend_input
    import bips_pkg::*;
#(
    parameter int MAC_W = 22,
    parameter int ADR_W = 9
)
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,

    // Data in
    input wire logic [MAC_W-1:0] mac_result,
    input wire logic [21:0] cascade_in,

    // Host register port
    input wire logic host_sel,
    input wire logic host_write,
    input wire logic [ADR_W-1:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,

    // Result bus to the transformation logic
    output logic [21:0] result_bus,
    output logic result_pos_ovf,
    output logic result_neg_ovf,

    // Table address with its flags
    output logic [7:0] table_addr,
    output logic addr_over_select,
    output logic addr_under_select,
    output logic addr_pos_ovf,
    output logic addr_neg_ovf
);

    // ------
    // Elaboration checks
    // ------

    generate
        if (MAC_W < 1 || MAC_W > 22)
            $error("bips_backend_input: MAC_W must be 1 to 22");
        if (ADR_W < 9)
            $error("bips_backend_input: ADR_W must be at least 9");
    endgenerate

    // ------
    // Helpers
    // ------

    function automatic logic [23:0] put_byte(input logic [23:0] old, input logic [1:0] idx,
        input logic [7:0] b);
        logic [23:0] r;
        r = old;
        case (idx)
            2'h0: r[7:0] = b;
            2'h1: r[15:8] = b;
            2'h2: r[23:16] = b;
            default: r = old;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] get_byte(input logic [23:0] w, input logic [1:0] idx);
        logic [7:0] r;
        case (idx)
            2'h0: r = w[7:0];
            2'h1: r = w[15:8];
            2'h2: r = w[23:16];
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    function automatic bips_mon_fn_t mon_decode(input logic [7:0] ctrl);
        bips_mon_fn_t f;
        case ({ctrl[`BIPS_MON_STATIC_BIT], ctrl[`BIPS_MON_MAX_BIT]}) // RULE_07 RULE_24
            2'b00: f = BIPS_MON_MIN;
            2'b01: f = BIPS_MON_MAX;
            2'b10: f = BIPS_MON_UNDER;
            2'b11: f = BIPS_MON_OVER;
            default: f = BIPS_MON_MIN;
        endcase
        return f;
    endfunction

    // ------
    // Host access decode
    // ------

    logic acc;
    logic wr;
    logic rd;
    logic [ADR_W-1:0] a;
    logic [1:0] thr_idx;
    logic [1:0] cnt_idx;
    logic thr_buf_hit;
    logic cnt_buf_hit;
    logic thr_copy_wr;
    logic thr_copy_rd;
    logic cnt_copy_wr;
    logic cnt_copy_rd;

    // A request is one cycle of host_sel; reads and writes never stall
    assign acc = clk_en && host_sel;
    assign wr = acc && host_write;
    assign rd = acc && !host_write;
    assign a = host_addr;
    assign thr_idx = 2'(a - ADR_W'(`BIPS_ADR_THR_BUF));
    assign cnt_idx = 2'(a - ADR_W'(`BIPS_ADR_CNT_BUF));
    assign thr_buf_hit = (a >= ADR_W'(`BIPS_ADR_THR_BUF))
        && (a < ADR_W'(`BIPS_ADR_THR_BUF) + ADR_W'(3));
    assign cnt_buf_hit = (a >= ADR_W'(`BIPS_ADR_CNT_BUF))
        && (a < ADR_W'(`BIPS_ADR_CNT_BUF) + ADR_W'(3));
    assign thr_copy_wr = wr && (a == ADR_W'(`BIPS_ADR_THR_COPY)); // RULE_15
    assign thr_copy_rd = rd && (a == ADR_W'(`BIPS_ADR_THR_COPY)); // RULE_16
    assign cnt_copy_wr = wr && (a == ADR_W'(`BIPS_ADR_CNT_COPY)); // RULE_17
    assign cnt_copy_rd = rd && (a == ADR_W'(`BIPS_ADR_CNT_COPY)); // RULE_17

    // ------
    // Control registers
    // ------

    logic [7:0] input_stage_control_reg;
    logic [7:0] monitor_control_reg;
    logic [7:0] prescale_control_reg;
    logic [7:0] system_control_reg;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            input_stage_control_reg <= `BIPS_CTRL_RESET;
            monitor_control_reg <= `BIPS_CTRL_RESET; // RULE_23
            prescale_control_reg <= `BIPS_CTRL_RESET;
            system_control_reg <= `BIPS_CTRL_RESET;
        end
        else if (wr)
        begin
            if (a == ADR_W'(`BIPS_ADR_IN_CTRL))
                input_stage_control_reg <= host_wdata;
            if (a == ADR_W'(`BIPS_ADR_MON_CTRL))
                monitor_control_reg <= host_wdata;
            if (a == ADR_W'(`BIPS_ADR_PRE_CTRL))
                prescale_control_reg <= host_wdata;
            if (a == ADR_W'(`BIPS_ADR_SYS_CTRL))
                system_control_reg <= host_wdata;
        end
    end

    // ------
    // Input stage
    // ------

    logic [21:0] mac_ext;
    logic [21:0] x_bus;
    logic x_pos;
    logic x_neg;

    assign mac_ext = 22'($signed(mac_result));

    bips_input_stage #(
        .W(22)
    ) u_input (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .mac_word(mac_ext),
        .cascade_in(cascade_in),
        .shift_code(input_stage_control_reg[`BIPS_SHIFT_MSB:`BIPS_SHIFT_LSB]),
        .cascade_zero(input_stage_control_reg[`BIPS_CASC_ZERO_BIT]),
        .rect_sel(input_stage_control_reg[`BIPS_RECT_MSB:`BIPS_RECT_LSB]),
        .result_bus(x_bus),
        .pos_ovf(x_pos),
        .neg_ovf(x_neg)
    );

    // Monitor only observes x_bus; the outputs are the bus itself
    assign result_bus = x_bus; // RULE_06
    assign result_pos_ovf = x_pos; // RULE_05
    assign result_neg_ovf = x_neg; // RULE_05

    // ------
    // Statistics monitor
    // ------

    logic [23:0] threshold_register_reg;
    logic [23:0] threshold_buffer_reg;
    logic [21:0] event_counter_reg;
    logic [21:0] event_count_buffer_reg;
    bips_mon_fn_t mon_fn;
    logic x_gt;
    logic x_lt;
    logic mon_hit;
    logic mon_load;
    logic [21:0] thr_val;
    logic [23:0] cnt_buf_wide;

    assign mon_fn = mon_decode(monitor_control_reg);
    assign thr_val = threshold_register_reg[21:0];
    assign cnt_buf_wide = {2'b00, event_count_buffer_reg};

    // Overflowed samples compare by their true sign, not the wrapped value
    always_comb
    begin
        x_gt = x_pos || (!x_neg && ($signed(x_bus) > $signed(thr_val))); // RULE_08
        x_lt = x_neg || (!x_pos && ($signed(x_bus) < $signed(thr_val))); // RULE_10
        mon_hit = 1'b0;
        mon_load = 1'b0;
        case (mon_fn)
            BIPS_MON_MAX:
            begin
                mon_hit = x_gt && !x_pos && !x_neg; // RULE_11 RULE_12
                mon_load = mon_hit;
            end
            BIPS_MON_MIN:
            begin
                mon_hit = x_lt && !x_pos && !x_neg; // RULE_11 RULE_12
                mon_load = mon_hit;
            end
            BIPS_MON_OVER:
                mon_hit = x_gt; // RULE_08
            BIPS_MON_UNDER:
                mon_hit = x_lt; // RULE_10
            default:
                mon_hit = 1'b0;
        endcase
    end

    // Copy write beats a capture in the same cycle; a new overflow
    // still sets its sticky bit over the clear
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            threshold_register_reg <= '0;
        else if (clk_en)
        begin
            if (thr_copy_wr)
            begin
                threshold_register_reg[21:0] <= threshold_buffer_reg[21:0]; // RULE_15 RULE_18
                threshold_register_reg[`BIPS_POS_STICKY_BIT] <= x_pos; // RULE_14
                threshold_register_reg[`BIPS_NEG_STICKY_BIT] <= x_neg; // RULE_14
            end
            else
            begin
                if (mon_load)
                    threshold_register_reg[21:0] <= x_bus; // RULE_11
                if (x_pos)
                    threshold_register_reg[`BIPS_POS_STICKY_BIT] <= 1'b1; // RULE_13
                if (x_neg)
                    threshold_register_reg[`BIPS_NEG_STICKY_BIT] <= 1'b1; // RULE_13
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            event_counter_reg <= '0;
        else if (clk_en)
        begin
            if (cnt_copy_wr)
                event_counter_reg <= event_count_buffer_reg; // RULE_17 RULE_18
            else if (mon_hit && event_counter_reg != `BIPS_CNT_MAX)
                event_counter_reg <= event_counter_reg + 22'h000001; // RULE_09
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            threshold_buffer_reg <= '0;
        else if (thr_copy_rd)
            threshold_buffer_reg <= threshold_register_reg; // RULE_16
        else if (wr && thr_buf_hit)
            threshold_buffer_reg <= put_byte(threshold_buffer_reg, thr_idx, host_wdata);
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            event_count_buffer_reg <= '0;
        else if (cnt_copy_rd)
            event_count_buffer_reg <= event_counter_reg; // RULE_17
        else if (wr && cnt_buf_hit)
            event_count_buffer_reg <= 22'(put_byte(cnt_buf_wide, cnt_idx, host_wdata));
    end

    // ------
    // Host read data
    // ------

    // Copy locations read as zero; their effect is the snapshot
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            host_rdata <= 8'h00;
        else if (rd)
        begin
            if (a == ADR_W'(`BIPS_ADR_IN_CTRL))
                host_rdata <= input_stage_control_reg;
            else if (a == ADR_W'(`BIPS_ADR_MON_CTRL))
                host_rdata <= monitor_control_reg;
            else if (a == ADR_W'(`BIPS_ADR_PRE_CTRL))
                host_rdata <= prescale_control_reg;
            else if (a == ADR_W'(`BIPS_ADR_SYS_CTRL))
                host_rdata <= system_control_reg;
            else if (thr_buf_hit)
                host_rdata <= get_byte(threshold_buffer_reg, thr_idx);
            else if (cnt_buf_hit)
                host_rdata <= get_byte(cnt_buf_wide, cnt_idx);
            else
                host_rdata <= 8'h00;
        end
    end

    // ------
    // Prescaler and select detector
    // ------

    logic [4:0] pre_amt;
    logic [21:0] pre_shifted;
    logic sel_fault;
    logic unsigned_addr;

    // Amounts above 16 are clamped rather than refused
    always_comb
    begin
        pre_amt = prescale_control_reg[`BIPS_PRE_AMT_MSB:0];
        if (pre_amt > `BIPS_PRE_MAX)
            pre_amt = `BIPS_PRE_MAX;
        pre_shifted = 22'($signed(x_bus) >>> pre_amt); // RULE_19
        unsigned_addr = system_control_reg[`BIPS_UNSIGNED_ADDR_BIT];
        if (unsigned_addr)
            sel_fault = (pre_shifted[21:8] != 14'h0000); // RULE_21
        else
            sel_fault = (pre_shifted[21:8] != {14{pre_shifted[7]}}); // RULE_20
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            table_addr <= 8'h00;
            addr_over_select <= 1'b0;
            addr_under_select <= 1'b0;
            addr_pos_ovf <= 1'b0;
            addr_neg_ovf <= 1'b0;
        end
        else if (clk_en)
        begin
            table_addr <= pre_shifted[7:0]; // RULE_19 RULE_25
            addr_over_select <= sel_fault && !x_bus[21]; // RULE_20 RULE_21
            addr_under_select <= sel_fault && x_bus[21]; // RULE_20 RULE_21
            addr_pos_ovf <= x_pos; // RULE_22
            addr_neg_ovf <= x_neg; // RULE_22
        end
    end

endmodule

// ---- tb/bips_mac_src.sv ----
// Model of the MAC array and the upstream cascaded device.
// Assumes the bench calls put once per sample; values hold until replaced.
module bips_mac_src
(
    // Clock
    input wire logic ref_clk,
    // Samples
    output logic [21:0] mac_result,
    output logic [21:0] cascade_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        mac_result = 22'h0;
        cascade_in = 22'h0;
    end
    // Launch just after an edge so the block samples it cleanly
    task automatic put(input logic [21:0] m, input logic [21:0] c);
        @(posedge ref_clk);
        mac_result <= m;
        cascade_in <= c;
    endtask
endmodule

// ---- tb/bips_backend_input_assertions.sv ----
// Checker on the host port and output flags of the backend input block.
// Assumes one ref_clk domain; bound to every instance of the block.
module bips_backend_input_chk #(
    parameter int ADR_W = 9
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Host port
    input wire logic host_sel,
    input wire logic host_write,
    input wire logic [ADR_W-1:0] host_addr,
    input wire logic [7:0] host_rdata,
    // Outputs
    input wire logic [21:0] result_bus,
    input wire logic result_pos_ovf,
    input wire logic result_neg_ovf,
    input wire logic addr_over_select,
    input wire logic addr_under_select,
    input wire logic addr_pos_ovf,
    input wire logic addr_neg_ovf
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    logic rd_req;
    assign rd_req = clk_en && host_sel && !host_write;
    copy_reads_zero_a: assert property (rd_req && host_addr == 9'h0b4 |=> host_rdata == 8'h00)
        else $error("copy location read not zero");
    rdata_holds_a: assert property (!rd_req |=> $stable(host_rdata))
        else $error("read data moved without read");
    ovf_exclusive_a: assert property (!(result_pos_ovf && result_neg_ovf))
        else $error("both overflow flags set");
    pos_ovf_align_a: assert property (clk_en |=> addr_pos_ovf == $past(result_pos_ovf))
        else $error("pos overflow misaligned");
    neg_ovf_align_a: assert property (clk_en |=> addr_neg_ovf == $past(result_neg_ovf))
        else $error("neg overflow misaligned");
    select_exclusive_a: assert property (!(addr_over_select && addr_under_select))
        else $error("over and under select together");
    pos_no_under_a: assert property (clk_en && !result_bus[21] |=> !addr_under_select)
        else $error("underselect on positive bus");
    neg_no_over_a: assert property (clk_en && result_bus[21] |=> !addr_over_select)
        else $error("overselect on negative bus");
endmodule
bind bips_backend_input bips_backend_input_chk #(.ADR_W(ADR_W)) i_chk (
    .ref_clk, .resetn, .clk_en, .host_sel, .host_write, .host_addr, .host_rdata,
    .result_bus, .result_pos_ovf, .result_neg_ovf, .addr_over_select,
    .addr_under_select, .addr_pos_ovf, .addr_neg_ovf);

// ---- tb/bips_backend_input_test.sv ----
// Self-checking bench for input stage, statistics monitor and prescaler.
// Assumes the source model feeds samples and the bench owns the host port.
`include "bips_params.svh"

module bips_backend_input_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic host_sel = 1'b0;
    logic host_write = 1'b0;
    logic [8:0] host_addr = 9'h0;
    logic [7:0] host_wdata = 8'h0;
    logic [7:0] host_rdata, table_addr;
    logic [21:0] mac_result, cascade_in, result_bus;
    logic result_pos_ovf, result_neg_ovf, addr_over_select, addr_under_select;
    logic addr_pos_ovf, addr_neg_ovf;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;

    always #2 ref_clk = ~ref_clk;

    bips_mac_src i_src (.ref_clk, .mac_result, .cascade_in);
    bips_backend_input i_dut (.ref_clk, .resetn, .clk_en(1'b1), .mac_result, .cascade_in,
        .host_sel, .host_write, .host_addr, .host_wdata, .host_rdata, .result_bus,
        .result_pos_ovf, .result_neg_ovf, .table_addr, .addr_over_select,
        .addr_under_select, .addr_pos_ovf, .addr_neg_ovf);

    // ------
    // Reporting
    // ------
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            summarize();
        end
    end

    // ------
    // Host and stream helpers
    // ------
    task automatic hwr(input logic [8:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        host_sel <= 1'b1;
        host_write <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge ref_clk);
        host_sel <= 1'b0;
    endtask

    task automatic hrd(input logic [8:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        host_sel <= 1'b1;
        host_write <= 1'b0;
        host_addr <= a;
        @(posedge ref_clk);
        host_sel <= 1'b0;
        #1;
        d = host_rdata;
    endtask

    // Buffer bytes first, then the copy strobe
    task automatic wr24(input logic [8:0] cp, input logic [23:0] v);
        for (int i = 0; i < 3; i++)
            hwr(cp + 9'(i + 1), v[8*i +: 8]);
        hwr(cp, 8'h00);
    endtask

    task automatic rd24(input logic [8:0] cp, output logic [23:0] v);
        logic [7:0] b;
        hrd(cp, b);
        for (int i = 0; i < 3; i++)
        begin
            hrd(cp + 9'(i + 1), b);
            v[8*i +: 8] = b;
        end
    endtask

    task automatic pulse(input logic [21:0] m, input logic [21:0] c, input logic [21:0] base);
        i_src.put(m, c);
        i_src.put(base, 22'h0);
    endtask

    task automatic settle();
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    // ------
    // Scenarios
    // ------
    task automatic t_cap(input logic [7:0] mode, input logic [21:0] p1, input logic [21:0] p2,
        input logic [21:0] pm, input logic [21:0] pc, input logic [23:0] e);
        logic [23:0] v;
        if (mode != 8'h00)
            hwr(`BIPS_ADR_MON_CTRL, mode);
        i_src.put(22'h1f4, 22'h0);
        wr24(`BIPS_ADR_THR_COPY, 24'h1f4);
        wr24(`BIPS_ADR_CNT_COPY, 24'h0);
        pulse(p1, 22'h0, 22'h1f4);
        pulse(p2, 22'h0, 22'h1f4);
        pulse(pm, pc, 22'h1f4);
        settle();
        rd24(`BIPS_ADR_THR_COPY, v);
        chk(v, e);
        rd24(`BIPS_ADR_CNT_COPY, v);
        chk(v, 24'h1);
        $display("Test capture mode %h done", mode);
    endtask

    task automatic path_case(input logic [7:0] ctl, input logic [21:0] m, input logic [21:0] c,
        input logic [21:0] e, input logic [1:0] f);
        hwr(`BIPS_ADR_IN_CTRL, ctl);
        i_src.put(m, c);
        settle();
        chk(24'(result_bus), 24'(e));
        chk(24'({result_pos_ovf, result_neg_ovf}), 24'(f));
        chk(24'({addr_pos_ovf, addr_neg_ovf}), 24'(f));
    endtask

    task automatic t_path();
        path_case(8'h00, 22'h64, 22'h17, 22'h7b, 2'b00);
        path_case(8'h01, 22'h64, 22'h17, 22'h64, 2'b00);
        path_case(8'h05, 22'h7, 22'h17, 22'h2, 2'b00);
        path_case(8'h11, 22'h3fff00, 22'h0, 22'h3fffff, 2'b00);
        path_case(8'h31, 22'h3, 22'h0, 22'h300, 2'b00);
        path_case(8'h00, 22'h1fffff, 22'h1, 22'h200000, 2'b10);
        path_case(8'h00, 22'h200000, 22'h3fffff, 22'h1fffff, 2'b01);
        path_case(8'h41, 22'h3ffffb, 22'h0, 22'h5, 2'b00);
        path_case(8'h81, 22'h3ffffb, 22'h0, 22'h0, 2'b00);
        path_case(8'h81, 22'h5, 22'h0, 22'h5, 2'b00);
        path_case(8'hc1, 22'h3ffffb, 22'h0, 22'h3ffffb, 2'b00);
        $display("Test datapath done");
    endtask

    task automatic pre_case(input logic [7:0] pre, input logic [7:0] sys, input logic [21:0] m,
        input logic [7:0] a, input logic [1:0] f);
        hwr(`BIPS_ADR_PRE_CTRL, pre);
        hwr(`BIPS_ADR_SYS_CTRL, sys);
        i_src.put(m, 22'h0);
        settle();
        chk(24'(table_addr), 24'(a));
        chk(24'({addr_over_select, addr_under_select}), 24'(f));
    endtask

    task automatic t_pre();
        logic [7:0] b;
        hrd(9'h1ff, b);
        chk(24'(b), 24'h0);
        hwr(`BIPS_ADR_IN_CTRL, 8'h01);
        pre_case(8'h04, 8'h00, 22'h000ff0, 8'hff, 2'b10);
        pre_case(8'h04, 8'h00, 22'h000070, 8'h07, 2'b00);
        pre_case(8'h00, 8'h00, 22'h3fffff, 8'hff, 2'b00);
        pre_case(8'h00, 8'h00, 22'h3fff38, 8'h38, 2'b01);
        pre_case(8'h10, 8'h00, 22'h0a0000, 8'h0a, 2'b00);
        pre_case(8'h00, 8'h40, 22'h0000c8, 8'hc8, 2'b00);
        pre_case(8'h00, 8'h40, 22'h3fffff, 8'hff, 2'b01);
        pre_case(8'h00, 8'h40, 22'h000100, 8'h00, 2'b10);
        hwr(`BIPS_ADR_SYS_CTRL, 8'h00);
        $display("Test prescaler done");
    endtask

    // Pulses: two above, one of each overflow, one below the threshold
    task automatic t_count(input logic [7:0] mode, input logic [23:0] start, input logic [23:0] e);
        logic [23:0] v;
        hwr(`BIPS_ADR_IN_CTRL, 8'h00);
        hwr(`BIPS_ADR_MON_CTRL, mode);
        i_src.put(22'h64, 22'h0);
        wr24(`BIPS_ADR_THR_COPY, 24'h64);
        wr24(`BIPS_ADR_CNT_COPY, start);
        pulse(22'h65, 22'h0, 22'h64);
        pulse(22'h66, 22'h0, 22'h64);
        pulse(22'h1fffff, 22'h1, 22'h64);
        pulse(22'h200000, 22'h3fffff, 22'h64);
        pulse(22'h63, 22'h0, 22'h64);
        settle();
        rd24(`BIPS_ADR_CNT_COPY, v);
        chk(v, e);
        rd24(`BIPS_ADR_THR_COPY, v);
        chk(v, 24'hc00064);
        hwr(`BIPS_ADR_THR_COPY, 8'h00);
        rd24(`BIPS_ADR_THR_COPY, v);
        chk(v, 24'h000064);
        $display("Test counting mode %h done", mode);
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        t_cap(8'h00, 22'h12c, 22'h190, 22'h200000, 22'h3fffff, 24'h80012c);
        t_cap(8'h01, 22'h2bc, 22'h258, 22'h1fffff, 22'h000001, 24'h4002bc);
        t_path();
        t_pre();
        t_count(8'h03, 24'h0, 24'h3);
        t_count(8'h02, 24'h0, 24'h2);
        t_count(8'h03, 24'h3fffff, 24'h3fffff);
        summarize();
    end
endmodule
